// ===== rtl/scfc_pkg.sv
// Package: register map, field layout, reset values and clock divider table of the SPI port
package scfc_pkg;

   // Register addresses on the local port
   localparam logic [1:0] ADDR_DATA    = 2'h0;
   localparam logic [1:0] ADDR_CTRL    = 2'h1;
   localparam logic [1:0] ADDR_STAT    = 2'h2;

   // Control register field positions
   localparam int unsigned CTL_IRQ_EN  = 7;
   localparam int unsigned CTL_PORT_EN = 6;
   localparam int unsigned CTL_HALVE_D = 5;
   localparam int unsigned CTL_CTRL_SEL= 4;
   localparam int unsigned CTL_IDLE_LV = 3;
   localparam int unsigned CTL_PHASE   = 2;
   localparam int unsigned CTL_RATE_HI = 1;
   localparam int unsigned CTL_RATE_LO = 0;

   // Status register field positions
   localparam int unsigned STA_DONE    = 7;
   localparam int unsigned STA_WRITE_COLLISION_FLAG    = 6;
   localparam int unsigned STA_FAULT   = 4;

   // Values after reset
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] BYTE_RESET   = 8'h00;

   // Sixteen SCK edges make one byte
   localparam logic [3:0] EDGE_FIRST   = 4'h0;
   localparam logic [3:0] EDGE_LAST    = 4'hF;

   // Half SCK period minus one, in CPU clocks
   localparam int unsigned DIV_W       = 6;
   localparam logic [5:0] HALF_DIV4    = 6'h01;
   localparam logic [5:0] HALF_DIV8    = 6'h03;
   localparam logic [5:0] HALF_DIV16   = 6'h07;
   localparam logic [5:0] HALF_DIV32   = 6'h0F;
   localparam logic [5:0] HALF_DIV64   = 6'h1F;
   localparam logic [5:0] HALF_DIV128  = 6'h3F;

   // Rate code is {halve divisor, rate select}; unlisted codes use the slowest rate
   function automatic logic [5:0] half_count(input logic [2:0] rate);
      logic [5:0] val;
      val = HALF_DIV128;
      unique case (rate)
         3'b100: val = HALF_DIV4;
         3'b000: val = HALF_DIV8;
         3'b001: val = HALF_DIV16;
         3'b110: val = HALF_DIV32;
         3'b010: val = HALF_DIV64;
         3'b011: val = HALF_DIV128;
         default: val = HALF_DIV128;
      endcase
      return val;
   endfunction : half_count

endpackage : scfc_pkg

// ===== rtl/scfc_spi_port.sv
// SPI port: control/status/data registers, controller clock divider, shifter, collision and fault logic
`timescale 1ns/1ps
module scfc_spi_port (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   // Register port
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // CPU state and interrupt
   input  wire logic       cpu_halt,
   input  wire logic       cpu_int_mask,
   output logic            spi_irq,
   output logic            spi_pins_sel,
   // SCK pin
   input  wire logic       sck_in,
   output logic            sck_out,
   output logic            sck_oe_n,
   // MOSI pin
   input  wire logic       mosi_in,
   output logic            mosi_out,
   output logic            mosi_oe_n,
   // MISO pin
   input  wire logic       miso_in,
   output logic            miso_out,
   output logic            miso_oe_n,
   // Select input
   input  wire logic       ss_n_in
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers (index 0 SCK, 1 MOSI, 2 MISO, 3 select)

   logic [3:0]  pin_s1_ff;
   logic [3:0]  pin_s2_ff;
   logic        sck_prev_ff;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pin_s1_ff   <= 4'hF;
         pin_s2_ff   <= 4'hF;
         // Matches the synchroniser reset level so no false SCK edge follows reset
         sck_prev_ff <= 1'b1;
      end else begin
         pin_s1_ff   <= {ss_n_in, miso_in, mosi_in, sck_in};
         pin_s2_ff   <= pin_s1_ff;
         sck_prev_ff <= pin_s2_ff[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // State

   logic [7:0]  ctrl_ff;
   logic        done_ff;
   logic        write_collision_flag_ff;
   logic        fault_ff;
   logic        arm_done_ff;
   logic        arm_write_collision_flag_ff;
   logic        arm_fault_ff;
   logic [7:0]  sh_ff;
   logic [7:0]  rx_ff;
   logic [7:0]  rxbuf_ff;
   logic [3:0]  cnt_ff;
   logic        busy_ff;
   logic [5:0]  div_ff;
   logic        sck_ff;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Decode

   wire logic   run       = ~cpu_halt;
   wire logic   acc_data  = run & (wr | rd) & (addr == scfc_pkg::ADDR_DATA);
   wire logic   wr_data   = run & wr & (addr == scfc_pkg::ADDR_DATA);
   wire logic   rd_data   = run & rd & (addr == scfc_pkg::ADDR_DATA);
   wire logic   wr_ctrl   = run & wr & (addr == scfc_pkg::ADDR_CTRL);
   wire logic   acc_stat  = run & (wr | rd) & (addr == scfc_pkg::ADDR_STAT);

   wire logic   ss_low    = ~pin_s2_ff[3];
   wire logic   port_en   = ctrl_ff[scfc_pkg::CTL_PORT_EN];
   wire logic   is_ctl    = ctrl_ff[scfc_pkg::CTL_CTRL_SEL];
   wire logic   phase     = ctrl_ff[scfc_pkg::CTL_PHASE];
   wire logic   idle_lv   = ctrl_ff[scfc_pkg::CTL_IDLE_LV];
   wire logic [2:0] rate  = {ctrl_ff[scfc_pkg::CTL_HALVE_D], ctrl_ff[scfc_pkg::CTL_RATE_HI],
                             ctrl_ff[scfc_pkg::CTL_RATE_LO]};

   // Select low on a controller is a fault; a target never faults
   wire logic   fault_ev  = run & port_en & is_ctl & ss_low;
   wire logic   tgt_act   = port_en & ~is_ctl & ss_low;

   // Serial clock edges: divider in controller mode, pin transitions in target mode
   wire logic   div_tick  = run & port_en & is_ctl & busy_ff & (div_ff == '0);
   wire logic   tgt_edge  = run & tgt_act & (pin_s2_ff[0] ^ sck_prev_ff);
   wire logic   edge_ev   = div_tick | tgt_edge;
   wire logic   capture   = edge_ev & (cnt_ff[0] == phase);
   wire logic   launch    = edge_ev & (cnt_ff[0] != phase) & (cnt_ff != scfc_pkg::EDGE_FIRST);
   wire logic   last      = edge_ev & (cnt_ff == scfc_pkg::EDGE_LAST);
   wire logic   data_in   = is_ctl ? pin_s2_ff[2] : pin_s2_ff[1];

   // Collision: controller while shifting; target once select is low (phase 0) or after first edge
   wire logic   coll_cond = port_en & (is_ctl ? busy_ff : (tgt_act & (~phase | busy_ff)));
   wire logic   collide   = wr_data & coll_cond;
   wire logic   wr_block  = done_ff & ~arm_done_ff;
   wire logic   load      = wr_data & ~coll_cond & ~wr_block;
   wire logic   start     = load & is_ctl & port_en;

   // Flag clearing sequences; a set in the same cycle wins
   wire logic   clr_done  = rd_data & arm_done_ff;
   wire logic   clr_write_collision_flag  = acc_data & arm_write_collision_flag_ff;
   wire logic   clr_fault = wr_ctrl & arm_fault_ff;
   wire logic   set_ok    = ~fault_ff | arm_fault_ff;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Next state

   logic [7:0]  nxt_ctrl_ff;
   logic [7:0]  nxt_sh_ff;
   logic [7:0]  nxt_rx_ff;
   logic [3:0]  nxt_cnt_ff;
   logic        nxt_busy_ff;
   logic [5:0]  nxt_div_ff;
   logic        nxt_sck_ff;

   wire logic   nxt_done_ff   = run ? (last | (done_ff & ~clr_done)) : done_ff;
   wire logic   nxt_write_collision_flag_ff   = run ? (collide | (write_collision_flag_ff & ~clr_write_collision_flag)) : write_collision_flag_ff;
   wire logic   nxt_fault_ff  = run ? (fault_ev | (fault_ff & ~clr_fault)) : fault_ff;
   wire logic   nxt_arm_done  = nxt_done_ff & ~clr_done & (arm_done_ff | (acc_stat & done_ff));
   wire logic   nxt_arm_write_collision_flag  = nxt_write_collision_flag_ff & ~clr_write_collision_flag & (arm_write_collision_flag_ff | (acc_stat & write_collision_flag_ff));
   wire logic   nxt_arm_fault = nxt_fault_ff & ~clr_fault & (arm_fault_ff | (acc_stat & fault_ff));

   always_comb begin
      nxt_ctrl_ff = ctrl_ff;
      if (wr_ctrl) begin
         nxt_ctrl_ff = wdata;
         nxt_ctrl_ff[scfc_pkg::CTL_PORT_EN]  = wdata[scfc_pkg::CTL_PORT_EN] & set_ok;
         nxt_ctrl_ff[scfc_pkg::CTL_CTRL_SEL] = wdata[scfc_pkg::CTL_CTRL_SEL] & set_ok;
      end
      if (fault_ev) begin
         nxt_ctrl_ff[scfc_pkg::CTL_PORT_EN]  = 1'b0;
         nxt_ctrl_ff[scfc_pkg::CTL_CTRL_SEL] = 1'b0;
      end
   end

   always_comb begin
      nxt_sh_ff = sh_ff;
      if (load) begin
         nxt_sh_ff = wdata;
      end else if (launch) begin
         nxt_sh_ff = {sh_ff[6:0], 1'b0};
      end
   end

   always_comb begin
      nxt_rx_ff = rx_ff;
      if (capture) begin
         nxt_rx_ff = {rx_ff[6:0], data_in};
      end
   end

   always_comb begin
      nxt_cnt_ff  = cnt_ff;
      nxt_busy_ff = busy_ff;
      if (run) begin
         if (fault_ev || (!is_ctl && !tgt_act)) begin
            nxt_cnt_ff  = scfc_pkg::EDGE_FIRST;
            nxt_busy_ff = 1'b0;
         end else if (start) begin
            nxt_cnt_ff  = scfc_pkg::EDGE_FIRST;
            nxt_busy_ff = 1'b1;
         end else if (edge_ev) begin
            nxt_cnt_ff  = cnt_ff + 4'h1;
            nxt_busy_ff = ~last;
         end
      end
   end

   always_comb begin
      nxt_div_ff = div_ff;
      nxt_sck_ff = sck_ff;
      if (run) begin
         if (start || div_tick) begin
            nxt_div_ff = scfc_pkg::half_count(rate);
         end else if (div_ff != '0) begin
            nxt_div_ff = div_ff - 6'h01;
         end
         if (div_tick) begin
            nxt_sck_ff = ~sck_ff;
         end else if (!busy_ff || !is_ctl) begin
            nxt_sck_ff = idle_lv;
         end
      end
   end

   wire logic   nxt_ctl_drv = nxt_ctrl_ff[scfc_pkg::CTL_PORT_EN] & nxt_ctrl_ff[scfc_pkg::CTL_CTRL_SEL];
   wire logic   nxt_tgt_drv = nxt_ctrl_ff[scfc_pkg::CTL_PORT_EN] & ~nxt_ctrl_ff[scfc_pkg::CTL_CTRL_SEL] & ss_low
                              & (~nxt_ctrl_ff[scfc_pkg::CTL_PHASE] | nxt_busy_ff);
   wire logic   nxt_irq     = run & ctrl_ff[scfc_pkg::CTL_IRQ_EN] & ~cpu_int_mask
                              & (nxt_done_ff | nxt_fault_ff);

   logic [7:0]  rd_mux;
   always_comb begin
      unique case (addr)
         scfc_pkg::ADDR_DATA: rd_mux = rxbuf_ff;
         scfc_pkg::ADDR_CTRL: rd_mux = ctrl_ff;
         scfc_pkg::ADDR_STAT: rd_mux = {done_ff, write_collision_flag_ff, 1'b0, fault_ff, 4'h0};
         default:             rd_mux = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_ff      <= scfc_pkg::CTRL_RESET;
         done_ff      <= 1'b0;
         write_collision_flag_ff      <= 1'b0;
         fault_ff     <= 1'b0;
         arm_done_ff  <= 1'b0;
         arm_write_collision_flag_ff  <= 1'b0;
         arm_fault_ff <= 1'b0;
      end else begin
         ctrl_ff      <= nxt_ctrl_ff;
         done_ff      <= nxt_done_ff;
         write_collision_flag_ff      <= nxt_write_collision_flag_ff;
         fault_ff     <= nxt_fault_ff;
         arm_done_ff  <= run ? nxt_arm_done : arm_done_ff;
         arm_write_collision_flag_ff  <= run ? nxt_arm_write_collision_flag : arm_write_collision_flag_ff;
         arm_fault_ff <= run ? nxt_arm_fault : arm_fault_ff;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sh_ff    <= scfc_pkg::BYTE_RESET;
         rx_ff    <= scfc_pkg::BYTE_RESET;
         rxbuf_ff <= scfc_pkg::BYTE_RESET;
         cnt_ff   <= scfc_pkg::EDGE_FIRST;
         busy_ff  <= 1'b0;
         div_ff   <= '0;
         sck_ff   <= 1'b0;
      end else begin
         sh_ff    <= nxt_sh_ff;
         rx_ff    <= nxt_rx_ff;
         rxbuf_ff <= (last && !done_ff) ? nxt_rx_ff : rxbuf_ff;
         cnt_ff   <= nxt_cnt_ff;
         busy_ff  <= nxt_busy_ff;
         div_ff   <= nxt_div_ff;
         sck_ff   <= nxt_sck_ff;
      end
   end

   // Outputs except rdata are registered from next-state values so pins follow the state without lag
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rdata        <= 8'h00;
         spi_irq      <= 1'b0;
         spi_pins_sel <= 1'b0;
         sck_out      <= 1'b0;
         sck_oe_n     <= 1'b1;
         mosi_out     <= 1'b0;
         mosi_oe_n    <= 1'b1;
         miso_out     <= 1'b0;
         miso_oe_n    <= 1'b1;
      end else begin
         rdata        <= rd ? rd_mux : 8'h00;
         spi_irq      <= nxt_irq;
         spi_pins_sel <= nxt_ctrl_ff[scfc_pkg::CTL_PORT_EN];
         sck_out      <= nxt_sck_ff;
         sck_oe_n     <= ~nxt_ctl_drv;
         mosi_out     <= nxt_sh_ff[7];
         mosi_oe_n    <= ~nxt_ctl_drv;
         miso_out     <= nxt_sh_ff[7];
         miso_oe_n    <= ~nxt_tgt_drv;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence seq_fault_armed;
      arm_fault_ff && fault_ff;
   endsequence

   sequence seq_ctrl_write;
      wr_ctrl && !fault_ev;
   endsequence

   sequence seq_stat_read_done;
      acc_stat && done_ff && run;
   endsequence

   AST_FAULT_CLEAR: assert property (seq_fault_armed ##0 seq_ctrl_write |=> !fault_ff)
      else $error("fault flag not cleared by control write after status access");

   AST_FAULT_DROPS: assert property (fault_ev |=> fault_ff && !port_en && !is_ctl ##1 sck_oe_n)
      else $error("fault did not release the port and leave controller mode");

   AST_TARGET_NO_FAULT: assert property (!is_ctl && !fault_ff |=> !fault_ff)
      else $error("fault flag set while in target mode");

   AST_FAULT_REFUSE: assert property (fault_ff && !arm_fault_ff && !port_en && wr_ctrl |=> !port_en)
      else $error("port enable set while fault pending");

   AST_COLLIDE: assert property (wr_data && coll_cond && !last |=> write_collision_flag_ff && $stable(rxbuf_ff))
      else $error("write during transfer not flagged as collision");

   // The request is registered from next-state flags, so the antecedent looks at those
   AST_NO_IRQ_QUIET: assert property (!nxt_done_ff && !nxt_fault_ff |=> !spi_irq)
      else $error("interrupt raised without done or fault flag");

   AST_WRITE_COLLISION_FLAG_NO_IRQ: assert property (collide && !done_ff && !fault_ff && !last && !fault_ev |=> !spi_irq)
      else $error("write collision raised the interrupt");

   AST_IRQ_RAISE: assert property (done_ff && run && ctrl_ff[scfc_pkg::CTL_IRQ_EN] && !cpu_int_mask
                                   && !clr_done |=> spi_irq)
      else $error("interrupt not raised for done flag");

   AST_HALT_FREEZE: assert property (cpu_halt |=> $stable(sh_ff) && $stable(cnt_ff) && $stable(ctrl_ff)
                                     && !spi_irq)
      else $error("state changed or interrupt raised during halt");

   AST_OVERRUN_KEEP: assert property (done_ff |=> $stable(rxbuf_ff))
      else $error("receive buffer overwritten while done flag set");

   AST_BYTE_END: assert property (last && run |=> done_ff && !busy_ff)
      else $error("sixteenth edge did not end the byte");

   AST_DONE_CLEAR: assert property (seq_stat_read_done ##1 (rd_data && !last) |=> !done_ff)
      else $error("done flag not cleared by status then data read");

   AST_WR_BLOCK: assert property (wr_data && done_ff && !arm_done_ff |=> $stable(sh_ff) || $past(launch))
      else $error("data write accepted while done flag pending");

   AST_MISO_WAIT: assert property (!miso_oe_n && phase && !is_ctl |-> busy_ff)
      else $error("MISO driven before first edge with phase 1");

endmodule : scfc_spi_port

// ===== tb/scfc_far_model.sv
// Far-side SPI device model: acts as controller or target, MSB first, selectable clock mode
`timescale 1ns/1ps
module scfc_far_model #(
   parameter int HALF = 8
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // Mode and command
   input  wire logic       ctl,
   input  wire logic       clock_idle_level,
   input  wire logic       capture_edge_phase,
   input  wire logic       go,
   input  wire logic       sel,
   input  wire logic [7:0] tx,
   // Lines
   input  wire logic       sck_line,
   input  wire logic       mosi_line,
   input  wire logic       miso_line,
   output logic            sck_o,
   output logic            ss_n_o,
   output logic            out_bit,
   output logic            busy,
   output logic [7:0]      rx
);
   logic       sck_q_ff;
   logic [3:0] k_ff;
   logic [3:0] t_ff;
   logic [7:0] d_ff;
   logic [7:0] tx_ff;
   wire  [3:0] j = k_ff - {3'h0, capture_edge_phase};

   assign ss_n_o  = ~sel;
   // Bits not yet due or already sent read as one, like a released line with pull-up
   assign out_bit = (k_ff < {3'h0, capture_edge_phase} || j > 4'h7) ? 1'b1 : tx_ff[3'h7 - j[2:0]];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {sck_q_ff, sck_o, busy} <= 3'h0;
         {k_ff, t_ff} <= 8'h00;
         {d_ff, tx_ff, rx} <= 24'h00_0000;
      end else begin
         sck_q_ff <= sck_line;
         if (go) begin
            {k_ff, t_ff} <= 8'h00;
            {d_ff, rx} <= 16'h0000;
            tx_ff <= tx;
            busy <= ctl;
         end else begin
            if (sck_line != sck_q_ff) begin
               // Capture on the leading edge for phase 0, trailing edge for phase 1
               if ((sck_line != clock_idle_level) != capture_edge_phase) rx <= {rx[6:0], ctl ? miso_line : mosi_line};
               else k_ff <= k_ff + 4'h1;
            end
            if (busy && d_ff == 8'(HALF - 1)) begin
               d_ff <= 8'h00;
               sck_o <= ~sck_o;
               t_ff <= t_ff + 4'h1;
               busy <= (t_ff != 4'hF);
            end else if (busy) d_ff <= d_ff + 8'h01;
            else sck_o <= clock_idle_level;
         end
      end
   end
endmodule : scfc_far_model

// ===== tb/spi_collision_fault_control_tb_top.sv
// Testbench of the SPI port: registers, controller rates, collisions, fault, target and halt
`timescale 1ns/1ps
module spi_collision_fault_control_tb_top;
   typedef struct packed {logic [7:0] ctl; logic [7:0] dv; logic [7:0] tx; logic [7:0] mt;} scfc_row_t;
   logic       ref_clk, nrst, wr, rd, cpu_halt, cpu_int_mask, sp;
   logic [1:0] addr;
   logic [7:0] wdata, rdata, v, m_tx, m_rx;
   logic       spi_irq, spi_pins_sel, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
   logic       m_ctl, m_clock_idle_level, m_capture_edge_phase, m_go, m_sel, m_sck, m_ss_n, m_out, m_busy;
   wire        sck_line  = !sck_oe_n ? sck_out : m_sck;
   wire        mosi_line = !mosi_oe_n ? mosi_out : (m_ctl ? m_out : 1'b1);
   wire        miso_line = !miso_oe_n ? miso_out : (m_ctl ? 1'b1 : m_out);
   int         n_fail = 0, checked = 0, c1, n;
   scfc_row_t  rows [6] = '{'{8'h70, 8'h04, 8'hA5, 8'hFF}, '{8'h50, 8'h08, 8'h3C, 8'h96},
                            '{8'h5D, 8'h10, 8'hC3, 8'h5A}, '{8'h76, 8'h20, 8'h81, 8'h7E},
                            '{8'h5A, 8'h40, 8'h01, 8'h80}, '{8'h53, 8'h80, 8'hFE, 8'h33}};
   localparam logic [1:0] DA = scfc_pkg::ADDR_DATA;
   localparam logic [1:0] CT = scfc_pkg::ADDR_CTRL;
   localparam logic [1:0] ST = scfc_pkg::ADDR_STAT;

   scfc_spi_port DUT (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .cpu_halt(cpu_halt), .cpu_int_mask(cpu_int_mask), .spi_irq(spi_irq),
      .spi_pins_sel(spi_pins_sel), .sck_in(sck_line), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
      .mosi_in(mosi_line), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_line),
      .miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_n_in(m_ss_n));
   scfc_far_model #(.HALF(8)) far (.clk(ref_clk), .nrst(nrst), .ctl(m_ctl), .clock_idle_level(m_clock_idle_level), .capture_edge_phase(m_capture_edge_phase),
      .go(m_go), .sel(m_sel), .tx(m_tx), .sck_line(sck_line), .mosi_line(mosi_line), .miso_line(miso_line),
      .sck_o(m_sck), .ss_n_o(m_ss_n), .out_bit(m_out), .busy(m_busy), .rx(m_rx));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask : chk
   task automatic rchk(input logic [1:0] a, input logic [7:0] e, input string nm);
      @(posedge ref_clk);
      {addr, rd} <= {a, 1'b1};
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      chk(nm, e, rdata);
   endtask : rchk
   task automatic xfer(input logic [7:0] t);
      @(posedge ref_clk);
      {m_tx, m_go} <= {t, 1'b1};
      @(posedge ref_clk);
      m_go <= 1'b0;
      tick(2);
      for (int c = 0; c < 400 && m_busy; c++) tick(1);
      tick(6);
   endtask : xfer
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #600000;
      n_fail++;
      test_done();
   end
   initial begin
      {nrst, wr, rd, addr, wdata, cpu_halt, cpu_int_mask} = '0;
      {m_ctl, m_clock_idle_level, m_capture_edge_phase, m_go, m_sel, m_tx} = '0;
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      tick(3);
      rchk(CT, 8'h00, "ctrl");
      rchk(ST, 8'h00, "stat");
      rchk(2'h3, 8'h00, "unmapped");
      chk("pins", 8'h00, {7'h0, spi_pins_sel});
      chk("oe_n", 8'h07, {5'h0, sck_oe_n, mosi_oe_n, miso_oe_n});
      $display("test reset done");
      foreach (rows[i]) begin
         @(posedge ref_clk);
         {m_clock_idle_level, m_capture_edge_phase} <= rows[i].ctl[3:2];
         wreg(CT, rows[i].ctl);
         xfer(rows[i].mt);
         chk("idle", {7'h0, rows[i].ctl[3]}, {7'h0, sck_out});
         wreg(DA, rows[i].tx);
         {n, c1, sp} = {32'd0, 32'd0, sck_out};
         for (int c = 0; c < int'(rows[i].dv) * 8 + 10; c++) begin
            tick(1);
            if (sck_out !== sp) n++;
            if (sck_out !== sp && n == 1) c1 = c;
            if (sck_out !== sp && n == 2) chk("half", {1'b0, rows[i].dv[7:1]}, 8'(c - c1));
            sp = sck_out;
         end
         chk("toggles", 8'h10, 8'(n));
         chk("idle end", {7'h0, rows[i].ctl[3]}, {7'h0, sck_out});
         rchk(ST, 8'h80, "stat");
         rchk(DA, rows[i].mt, "rx");
         chk("far rx", rows[i].tx, m_rx);
         rchk(ST, 8'h00, "stat clr");
      end
      $display("test rates done");
      @(posedge ref_clk);
      {m_clock_idle_level, m_capture_edge_phase} <= 2'b00;
      wreg(CT, 8'hD0);
      xfer(8'h6B);
      wreg(DA, 8'h11);
      wreg(DA, 8'h22);
      tick(1);
      chk("irq", 8'h00, {7'h0, spi_irq});
      tick(80);
      chk("irq", 8'h01, {7'h0, spi_irq});
      rchk(ST, 8'hC0, "write_collision_flag");
      rchk(DA, 8'h6B, "rx");
      chk("far rx", 8'h11, m_rx);
      rchk(ST, 8'h00, "write_collision_flag clr");
      chk("irq", 8'h00, {7'h0, spi_irq});
      xfer(8'h6B);
      wreg(DA, 8'h44);
      tick(80);
      wreg(DA, 8'h55);
      tick(80);
      chk("far rx", 8'h44, m_rx);
      @(posedge ref_clk) cpu_int_mask <= 1'b1;
      tick(3);
      chk("irq mask", 8'h00, {7'h0, spi_irq});
      @(posedge ref_clk) {cpu_int_mask, cpu_halt} <= 2'b01;
      tick(3);
      chk("irq halt", 8'h00, {7'h0, spi_irq});
      wreg(CT, 8'h00);
      @(posedge ref_clk) cpu_halt <= 1'b0;
      rchk(CT, 8'hD0, "ctrl frozen");
      rchk(ST, 8'h80, "no write_collision_flag");
      rchk(DA, 8'h6B, "rx");
      $display("test collision done");
      @(posedge ref_clk) m_sel <= 1'b1;
      tick(6);
      chk("irq fault", 8'h01, {7'h0, spi_irq});
      chk("pins", 8'h00, {7'h0, spi_pins_sel});
      chk("sck oe_n", 8'h01, {7'h0, sck_oe_n});
      chk("mosi oe_n", 8'h01, {7'h0, mosi_oe_n});
      rchk(CT, 8'h80, "ctrl fault");
      @(posedge ref_clk) m_sel <= 1'b0;
      wreg(CT, 8'hD0);
      rchk(CT, 8'h80, "refused");
      rchk(ST, 8'h10, "fault");
      wreg(CT, 8'hD0);
      rchk(ST, 8'h00, "fault clr");
      rchk(CT, 8'hD0, "restored");
      $display("test fault done");
      @(posedge ref_clk) {m_ctl, m_capture_edge_phase} <= 2'b11;
      wreg(CT, 8'h44);
      wreg(DA, 8'hB2);
      @(posedge ref_clk) m_sel <= 1'b1;
      tick(6);
      chk("miso oe_n", 8'h01, {7'h0, miso_oe_n});
      xfer(8'h4D);
      chk("far rx", 8'hB2, m_rx);
      rchk(ST, 8'h80, "target stat");
      xfer(8'h99);
      rchk(ST, 8'h80, "overrun stat");
      rchk(DA, 8'h4D, "overrun rx");
      @(posedge ref_clk) m_sel <= 1'b0;
      wreg(CT, 8'h40);
      @(posedge ref_clk) m_sel <= 1'b1;
      tick(5);
      wreg(DA, 8'h12);
      rchk(ST, 8'h40, "target write_collision_flag");
      @(posedge ref_clk) m_sel <= 1'b0;
      $display("test target done");
      test_done();
   end
endmodule : spi_collision_fault_control_tb_top
